// ### logic/rail_seq_pkg.sv
/*
  Constants for the rail sequencer and wake event logic.
  Assumes a 40 MHz system clock; every time is converted to cycles here.
*/
`default_nettype none
package rail_seq_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int WAKE_PULSE_MS = 90;
  localparam int WAKE_PULSE_CYC = (CLK_HZ / 1000) * WAKE_PULSE_MS;
  localparam int RAIL_STEP_US = 1000;
  localparam int RAIL_STEP_CYC = (CLK_HZ / 1000000) * RAIL_STEP_US;

  // ----------------------------------------------------------------------
  // Rails and sequences
  // ----------------------------------------------------------------------
  localparam int NUM_RAILS = 4;
  localparam logic [1:0] BOOST_RAIL = 2'h0;
  localparam logic [1:0] BUCK_BOOST_RAIL = 2'h1;
  localparam logic [1:0] CORE_BUCK_RAIL = 2'h2;
  localparam logic [1:0] MEMORY_BUCK_RAIL = 2'h3;
  localparam int NUM_SEQUENCES = 6;
  localparam int NUM_EVENTS = 8;

endpackage
`default_nettype wire

// ### logic/pulse_timer.sv
/*
  Non-retriggerable one-shot: a start pulse opens a window of a fixed number
  of cycles; starts during the window are ignored.
  Assumes start_i comes from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pulse_timer #(
  parameter int LENGTH = rail_seq_pkg::WAKE_PULSE_CYC
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  output logic active_o
);

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  localparam int W = $clog2(LENGTH + 1);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // Elaboration stops here, since a zero length would never open a window.
  if (LENGTH < 1)
  begin
    $error("pulse_timer LENGTH must be at least one");
  end

  // A start only loads an idle counter, so the pulse is never stretched.
  always_comb
  begin
    count_d = count_q;
    if (count_q != '0)
    begin
      count_d = count_q - W'(1);
    end
    else if (start_i)
    begin
      count_d = W'(LENGTH);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign active_o = (count_q != '0);

endmodule
`default_nettype wire

// ### logic/rail_sequencer_wake_events.sv
/*
  Rail sequencer, wake pulse generator and event interrupt of a power unit.
  Assumes the strap, enable, plug and event inputs are asynchronous pins,
  and that the interrupt clear comes from the control-bus logic on clock_i.
*/
`timescale 1ns/10ps
`default_nettype none
// Function
// - The level on the sequence strap picks one of six rail orders for power-on and power-off.
// - Sequence 0 brings up buck-boost, then core buck, then memory buck, and never the boost rail.
// - Sequence 1 brings up boost, core buck, buck-boost, then memory buck.
// - Sequence 3 brings up boost, buck-boost, memory buck, then core buck.
// - Sequence 4 brings up boost, memory buck, core buck, then buck-boost.
// - Sequence 5 brings up boost, memory buck, buck-boost, then core buck.
// - A fresh supply or battery plug-in drives the wake output high for one 90 ms pulse.
// - Every rail that is off has its discharge path switched on.
// - While the converter is enabled, the eight charger and supply events raise the interrupt.
// - An event pulls the open-drain interrupt low and sets the flag, which a host zero-write clears.
// - The strap order governs only the four sequenced rails.
module rail_sequencer_wake_events #(
  parameter int WAKE_CYCLES = rail_seq_pkg::WAKE_PULSE_CYC,
  parameter int STEP_CYCLES = rail_seq_pkg::RAIL_STEP_CYC
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] sequence_select_strap_i,
  input wire logic converter_enable_i,
  input wire logic supply_input_present_i,
  input wire logic battery_input_present_i,
  input wire logic [7:0] event_i,
  input wire logic irq_clear_i,
  output logic [3:0] rail_enable_o,
  output logic [3:0] rail_discharge_o,
  output logic wake_o,
  output logic irq_flag_o,
  output logic irq_n_o,
  output logic irq_oe_n_o
);

  // ----------------------------------------------------------------------
  // Checks and synchronisers
  // ----------------------------------------------------------------------
  // Elaboration stops here if a count cannot be served by the counters.
  if (WAKE_CYCLES < 1 || STEP_CYCLES < 1)
  begin
    $error("cycle counts must be at least one");
  end

  localparam int SW = 14;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;

  // Two flops on every pin input; only sync2_q is read by logic.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {event_i, battery_input_present_i, supply_input_present_i,
                  converter_enable_i, sequence_select_strap_i};
      sync2_q <= sync1_q;
    end
  end

  logic [2:0] strap_s;
  logic enable_s;
  logic supply_s;
  logic battery_s;
  logic [7:0] event_s;
  assign strap_s = sync2_q[2:0];
  assign enable_s = sync2_q[3];
  assign supply_s = sync2_q[4];
  assign battery_s = sync2_q[5];
  assign event_s = sync2_q[13:6];

  // ----------------------------------------------------------------------
  // Sequence table
  // ----------------------------------------------------------------------
  // Returns the rail at a given step of a sequence; valid is low past the end.
  function automatic logic [2:0] seq_step(input logic [2:0] sel, input logic [1:0] step);
    logic [7:0] order;
    logic [2:0] len;
    order = 8'h00;
    len = 3'h4;
    case (sel)
      3'h0:
      begin
        order = {2'h0, rail_seq_pkg::MEMORY_BUCK_RAIL, rail_seq_pkg::CORE_BUCK_RAIL,
                 rail_seq_pkg::BUCK_BOOST_RAIL};
        len = 3'h3;
      end
      3'h1: order = {rail_seq_pkg::MEMORY_BUCK_RAIL, rail_seq_pkg::BUCK_BOOST_RAIL,
                     rail_seq_pkg::CORE_BUCK_RAIL, rail_seq_pkg::BOOST_RAIL};
      3'h2: order = {rail_seq_pkg::BUCK_BOOST_RAIL, rail_seq_pkg::MEMORY_BUCK_RAIL,
                     rail_seq_pkg::CORE_BUCK_RAIL, rail_seq_pkg::BOOST_RAIL};
      3'h3: order = {rail_seq_pkg::CORE_BUCK_RAIL, rail_seq_pkg::MEMORY_BUCK_RAIL,
                     rail_seq_pkg::BUCK_BOOST_RAIL, rail_seq_pkg::BOOST_RAIL};
      3'h4: order = {rail_seq_pkg::BUCK_BOOST_RAIL, rail_seq_pkg::CORE_BUCK_RAIL,
                     rail_seq_pkg::MEMORY_BUCK_RAIL, rail_seq_pkg::BOOST_RAIL};
      default: order = {rail_seq_pkg::CORE_BUCK_RAIL, rail_seq_pkg::BUCK_BOOST_RAIL,
                        rail_seq_pkg::MEMORY_BUCK_RAIL, rail_seq_pkg::BOOST_RAIL};
    endcase
    seq_step = {({1'b0, step} < len), order[2*step +: 2]};
  endfunction

  // ----------------------------------------------------------------------
  // Sequencer state machine
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {OFF_ST, UP_ST, ON_ST, DOWN_ST} seq_state_type;
  localparam int TW = $clog2(STEP_CYCLES + 1);
  seq_state_type state_q;
  seq_state_type state_d;
  logic [2:0] sel_q;
  logic [2:0] sel_d;
  logic [1:0] step_q;
  logic [1:0] step_d;
  logic [TW-1:0] timer_q;
  logic [TW-1:0] timer_d;
  logic [3:0] rails_q;
  logic [3:0] rails_d;
  logic [2:0] cur;
  logic [1:0] last_step;

  assign cur = seq_step(sel_q, step_q);
  assign last_step = (sel_q == 3'h0) ? 2'h2 : 2'h3;

  // The strap is latched only when leaving OFF so the off order matches the on order.
  always_comb
  begin
    state_d = state_q;
    sel_d = sel_q;
    step_d = step_q;
    rails_d = rails_q;
    timer_d = (timer_q != '0) ? timer_q - TW'(1) : timer_q;
    case (state_q)
      OFF_ST:
      begin
        if (enable_s)
        begin
          sel_d = (strap_s < 3'(rail_seq_pkg::NUM_SEQUENCES)) ? strap_s : 3'h5;
          step_d = 2'h0;
          timer_d = '0;
          state_d = UP_ST;
        end
      end
      UP_ST:
      begin
        if (!enable_s)
        begin
          state_d = DOWN_ST;
          step_d = (step_q == 2'h0) ? 2'h0 : step_q - 2'h1;
          timer_d = TW'(STEP_CYCLES);
        end
        else if (timer_q == '0 && cur[2])
        begin
          rails_d[cur[1:0]] = 1'b1;
          timer_d = TW'(STEP_CYCLES);
          if (step_q == last_step)
          begin
            state_d = ON_ST;
          end
          else
          begin
            step_d = step_q + 2'h1;
          end
        end
      end
      ON_ST:
      begin
        if (!enable_s)
        begin
          // The step timer keeps running, so the first turn-off waits out
          // the gap after the last turn-on instead of following it at once.
          state_d = DOWN_ST;
        end
      end
      DOWN_ST:
      begin
        if (timer_q == '0)
        begin
          if (rails_q[cur[1:0]])
          begin
            rails_d[cur[1:0]] = 1'b0;
            timer_d = TW'(STEP_CYCLES);
          end
          else if (step_q == 2'h0)
          begin
            state_d = OFF_ST;
          end
          else
          begin
            step_d = step_q - 2'h1;
          end
        end
      end
      default: state_d = OFF_ST;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= OFF_ST;
      sel_q <= 3'h0;
      step_q <= 2'h0;
      timer_q <= '0;
      rails_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      sel_q <= sel_d;
      step_q <= step_d;
      timer_q <= timer_d;
      rails_q <= rails_d;
    end
  end

  // ----------------------------------------------------------------------
  // Wake pulse
  // ----------------------------------------------------------------------
  logic supply_prev_q;
  logic battery_prev_q;
  logic plug_event;
  logic wake_active;
  assign plug_event = (supply_s & ~supply_prev_q) | (battery_s & ~battery_prev_q);

  pulse_timer #(
    .LENGTH(WAKE_CYCLES)
  ) u_wake_timer (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .start_i(plug_event),
    .active_o(wake_active)
  );

  // ----------------------------------------------------------------------
  // Interrupt flag and registered outputs
  // ----------------------------------------------------------------------
  logic irq_flag_d;
  logic event_hit;
  assign event_hit = enable_s & (|event_s);
  // Set wins over a clear arriving in the same cycle.
  assign irq_flag_d = event_hit | (irq_flag_o & ~irq_clear_i);

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      supply_prev_q <= 1'b0;
      battery_prev_q <= 1'b0;
      irq_flag_o <= 1'b0;
      irq_oe_n_o <= 1'b1;
      wake_o <= 1'b0;
      rail_enable_o <= 4'h0;
      rail_discharge_o <= 4'hf;
    end
    else
    begin
      supply_prev_q <= supply_s;
      battery_prev_q <= battery_s;
      irq_flag_o <= irq_flag_d;
      irq_oe_n_o <= ~irq_flag_d;
      wake_o <= wake_active;
      rail_enable_o <= rails_d;
      rail_discharge_o <= ~rails_d;
    end
  end

  // Open-drain pin only ever drives low.
  assign irq_n_o = 1'b0;

endmodule
`default_nettype wire

// ### sim/rail_seq_checker.sv
/* Port assertions for the rail sequencer.
   Assumes one clock and the design's synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module rail_seq_checker #(
  parameter int WAKE_CYCLES = 20,
  parameter int STEP_CYCLES = 5
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic converter_enable_i,
  input wire logic supply_input_present_i,
  input wire logic battery_input_present_i,
  input wire logic [7:0] event_i,
  input wire logic irq_clear_i,
  input wire logic [3:0] rail_enable_o,
  input wire logic [3:0] rail_discharge_o,
  input wire logic wake_o,
  input wire logic irq_flag_o,
  input wire logic irq_n_o,
  input wire logic irq_oe_n_o
);
  // Counts wake cycles so the width is judged exactly at the falling edge.
  logic [31:0] wake_cnt_q;
  logic [31:0] wake_cnt_d;
  always_comb wake_cnt_d = wake_o ? wake_cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge clock_i) wake_cnt_q <= sys_rst_i ? 32'h0 : wake_cnt_d;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  AST_DISCHARGE: assert property (rail_discharge_o == ~rail_enable_o)
    else $error("discharge is not the inverse of enable");
  AST_OE_FLAG: assert property (irq_oe_n_o == !irq_flag_o)
    else $error("interrupt pin does not follow flag");
  AST_PIN_LOW: assert property (irq_n_o == 1'b0)
    else $error("interrupt data not low");
  AST_FLAG_STICKY: assert property (irq_flag_o && !irq_clear_i |=> irq_flag_o)
    else $error("flag dropped without clear");
  AST_EVENT_GATED: assert property ((!converter_enable_i)[*6] |-> !$rose(irq_flag_o))
    else $error("flag set while disabled");
  AST_ONE_RAIL: assert property ($countones(rail_enable_o ^ $past(rail_enable_o)) <= 1)
    else $error("two rails moved at once");
  AST_STEP_GAP: assert property ($changed(rail_enable_o) |=> $stable(rail_enable_o)[*4])
    else $error("rail steps too close");
  AST_WAKE_WIDTH: assert property ($fell(wake_o) |-> wake_cnt_q == WAKE_CYCLES)
    else $error("wake pulse width wrong");
  AST_WAKE_CAUSE: assert property ($rose(wake_o) |->
    $past(supply_input_present_i, 2) || $past(battery_input_present_i, 2))
    else $error("wake without plug-in");
  // Pins pass two sync flops, so an enabled event shows on the flag three edges on.
  AST_EVENT_SETS: assert property (converter_enable_i && (|event_i) |-> ##3 irq_flag_o)
    else $error("enabled event did not set the flag");
  AST_FLAG_CLEARS: assert property (irq_flag_o && irq_clear_i &&
    !$past(converter_enable_i && (|event_i), 2) |=> !irq_flag_o)
    else $error("flag not cleared by host");
endmodule
bind rail_sequencer_wake_events rail_seq_checker #(.WAKE_CYCLES(WAKE_CYCLES),
  .STEP_CYCLES(STEP_CYCLES)) chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .converter_enable_i(converter_enable_i), .supply_input_present_i(supply_input_present_i),
  .battery_input_present_i(battery_input_present_i), .irq_clear_i(irq_clear_i),
  .event_i(event_i),
  .rail_enable_o(rail_enable_o), .rail_discharge_o(rail_discharge_o), .wake_o(wake_o),
  .irq_flag_o(irq_flag_o), .irq_n_o(irq_n_o), .irq_oe_n_o(irq_oe_n_o));
`default_nettype wire

// ### sim/host_model.sv
/* Host processor model: drives the converter enable and clears the flag.
   Assumes the interrupt line has a pull-up and the design's clock. */
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clock_i,
  input wire logic run_i,
  input wire logic auto_clear_i,
  input wire logic irq_n_i,
  input wire logic irq_oe_n_i,
  output logic enable_o,
  output logic clear_o,
  output logic irq_line_o
);
  // The pull-up wins whenever the device lets the line go.
  assign irq_line_o = irq_oe_n_i ? 1'b1 : irq_n_i;
  // One-cycle clear pulses, never back to back, so a held line is re-seen.
  always @(posedge clock_i)
  begin
    enable_o <= run_i;
    clear_o <= auto_clear_i && !irq_line_o && !clear_o;
  end
  initial enable_o = 1'b0;
  initial clear_o = 1'b0;
endmodule
`default_nettype wire

// ### sim/rail_sequencer_wake_events_tb.sv
/* Self-checking bench for the rail sequencer.
   Assumes short wake and step counts; host_model stands at the far side. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module rail_sequencer_wake_events_tb;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, supply = 1'b0, battery = 1'b0;
  logic run = 1'b0, auto_clr = 1'b0, en, clr, irq_line, wake, flag, irq_n, oe_n;
  logic [2:0] strap = 3'h0;
  logic [7:0] ev = 8'h00;
  logic [3:0] rails, dis, prev;
  logic [15:0] on_ord, off_ord;
  int miscompares = 0, check_count = 0, n;

  // ----------------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------------
  initial forever #12.5 clock_i = ~clock_i;
  rail_sequencer_wake_events #(.WAKE_CYCLES(20), .STEP_CYCLES(5)) dut (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .sequence_select_strap_i(strap), .converter_enable_i(en),
    .supply_input_present_i(supply), .battery_input_present_i(battery), .event_i(ev),
    .irq_clear_i(clr), .rail_enable_o(rails), .rail_discharge_o(dis), .wake_o(wake),
    .irq_flag_o(flag), .irq_n_o(irq_n), .irq_oe_n_o(oe_n));
  host_model host (.clock_i(clock_i), .run_i(run), .auto_clear_i(auto_clr), .irq_n_i(irq_n),
    .irq_oe_n_i(oe_n), .enable_o(en), .clear_o(clr), .irq_line_o(irq_line));

  // Logs the order in which rails switch, one nibble per step.
  always @(posedge clock_i)
  begin
    prev <= rails;
    for (int i = 0; i < 4; i++)
    begin
      if (rails[i] && !prev[i]) on_ord = {on_ord[11:0], 4'(i)};
      if (!rails[i] && prev[i]) off_ord = {off_ord[11:0], 4'(i)};
    end
  end

  // ----------------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------------
  // Straps 6 and 7 fall back to the last order, as the design settles it.
  function automatic logic [15:0] exp_on(input logic [2:0] s);
    case (s)
      3'h0: return 16'hf123;
      3'h1: return 16'h0213;
      3'h2: return 16'h0231;
      3'h3: return 16'h0132;
      3'h4: return 16'h0321;
      default: return 16'h0312;
    endcase
  endfunction
  function automatic logic [15:0] rev(input logic [15:0] o);
    logic [15:0] r;
    r = 16'hffff;
    for (int i = 0; i < 4; i++)
      if (o[4*i+:4] != 4'hf) r = {r[11:0], o[4*i+:4]};
    return r;
  endfunction

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for a rail pattern; running out ends the run.
  task automatic wait_rails(input logic [3:0] m);
    n = 0;
    while (rails !== m && n < 400)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n == 400)
    begin
      miscompares++;
      wrap_up();
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h0030));
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    `CHK("rails", 4'h0, rails)
    `CHK("irq", 1'b1, irq_line)
    // Every strap, with the strap scrambled mid-ramp to prove it is latched.
    for (int s = 0; s < 8; s++)
    begin
      strap <= 3'(s);
      on_ord = 16'hffff;
      off_ord = 16'hffff;
      repeat (5) @(posedge clock_i);
      run <= 1'b1;
      repeat (6) @(posedge clock_i);
      strap <= 3'($urandom % 8);
      wait_rails(s == 0 ? 4'he : 4'hf);
      repeat (10) @(posedge clock_i);
      `CHK("on order", exp_on(3'(s)), on_ord)
      run <= 1'b0;
      wait_rails(4'h0);
      @(posedge clock_i);
      `CHK("off order", rev(exp_on(3'(s))), off_ord)
      `CHK("discharge", 4'hf, dis)
    end
    // Enable dropped mid-ramp: only the rails already on come off, newest first.
    strap <= 3'h3;
    off_ord = 16'hffff;
    run <= 1'b1;
    wait_rails(4'h3);
    run <= 1'b0;
    wait_rails(4'h0);
    @(posedge clock_i);
    `CHK("abort order", 16'hff10, off_ord)
    // Events while disabled are ignored.
    ev <= 8'hff;
    repeat (8) @(posedge clock_i);
    ev <= 8'h00;
    `CHK("flag off", 1'b0, flag)
    run <= 1'b1;
    repeat (8) @(posedge clock_i);
    // Each event alone, then a random mix; a short pulse must stick.
    for (int i = 0; i < 9; i++)
    begin
      ev <= (i == 8) ? 8'($urandom | 1) : 8'h01 << i;
      @(posedge clock_i);
      ev <= 8'h00;
      repeat (8) @(posedge clock_i);
      `CHK("flag", 1'b1, flag)
      `CHK("irq low", 1'b0, irq_line)
      auto_clr <= 1'b1;
      repeat (6) @(posedge clock_i);
      auto_clr <= 1'b0;
      `CHK("irq high", 1'b1, irq_line)
    end
    run <= 1'b0;
    // Wake pulse, with a second plug-in inside it.
    supply <= 1'b1;
    n = 0;
    while (!wake && n < 20)
    begin
      @(posedge clock_i);
      n++;
    end
    // A wake that never rises is a hang, so the run ends here.
    if (wake !== 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
    n = 0;
    while (wake === 1'b1 && n < 100)
    begin
      if (n == 5) battery <= 1'b1;
      @(posedge clock_i);
      n++;
    end
    `CHK("wake width", 20, n)
    repeat (10) @(posedge clock_i);
    `CHK("wake idle", 1'b0, wake)
    wrap_up();
  end
endmodule
`default_nettype wire
